// file: hdl/aeig_pkg.sv
`default_nettype none
package aeig_pkg;
  // register offsets on the byte-wide register port
  localparam logic [15:0] BLOCK_IRQ_ENABLE_OFS = 16'h0B00;
  localparam logic [15:0] ALARM_ERROR_IRQ_STATUS_OFS = 16'h0B02;
  localparam logic [15:0] ALARM_SRC_IRQ_ENABLE_OFS = 16'h0B03;
  localparam logic [15:0] FRAME_ERR_THRESHOLD_OFS = 16'h010B;
  // block enable fields
  localparam int unsigned SLIP_GROUP_BIT = 2;
  localparam int unsigned ALARM_GROUP_BIT = 1;
  localparam int unsigned FRAMER_GROUP_BIT = 0;
  // alarm status fields
  localparam int unsigned FRAME_LOSS_BIT = 7;
  localparam int unsigned ALL_ONES_BIT = 6;
  localparam int unsigned REMOTE_ALARM_BIT = 5;
  localparam int unsigned SIGNAL_LOSS_BIT = 4;
  localparam int unsigned LINE_CODE_BIT = 3;
  localparam int unsigned FRAME_LOSS_CHG_BIT = 2;
  localparam int unsigned ALL_ONES_CHG_BIT = 1;
  localparam int unsigned REMOTE_ALARM_CHG_BIT = 0;
  // threshold fields: window in [7:4], error count limit in [3:0]
  localparam int unsigned WINDOW_LSB = 4;
  localparam int unsigned LIMIT_LSB = 0;
  // reset values
  localparam logic [2:0] BLOCK_IRQ_ENABLE_RST = 3'h0;
  localparam logic [3:0] ALARM_SRC_IRQ_ENABLE_RST = 4'h0;
  localparam logic [3:0] STICKY_RST = 4'h0;
  localparam logic [3:0] FRAME_ERR_WINDOW_RST = 4'h4;
  localparam logic [3:0] FRAME_ERR_LIMIT_RST = 4'h2;
  // timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned AIS_PERSIST_MS = 42;
  localparam int unsigned RAI_PERSIST_MS = 900;
  localparam int unsigned AIS_CYCLES = AIS_PERSIST_MS * (CLK_HZ / 1000);
  localparam int unsigned RAI_CYCLES = RAI_PERSIST_MS * (CLK_HZ / 1000);
  localparam int unsigned RAI_CLEAR_CYCLES = 1;
  localparam int unsigned LOS_BITS = 175;
  localparam int unsigned ONES_DENSITY_PERMILLE = 125;
  localparam int unsigned LOS_ONES_MIN = (LOS_BITS * ONES_DENSITY_PERMILLE + 999) / 1000;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic bit_strobe;
    logic bit_one;
    logic los_raw;
    logic ais_raw;
    logic rai_raw;
    logic frame_bit_strobe;
    logic frame_bit_err;
    logic frame_sync_found;
    logic lcv_event;
  } rx_defect_t;

  typedef enum logic [0:0] {
    IN_FRAME = 1'b0,
    OUT_OF_FRAME = 1'b1
  } sync_state_t;

  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] ofs);
    return addr == ofs;
  endfunction : addr_hit
endpackage : aeig_pkg
`default_nettype wire

// file: hdl/persist_filter.sv
`timescale 1ns/1ps
`default_nettype none
module persist_filter
  import aeig_pkg::*;
#(
  parameter int unsigned SET_CYCLES = AIS_CYCLES,
  parameter int unsigned CLR_CYCLES = AIS_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cond,
  output logic state
);
  localparam int unsigned MAXC = (SET_CYCLES > CLR_CYCLES) ? SET_CYCLES : CLR_CYCLES;
  localparam int unsigned W = $clog2(MAXC + 1) + 1;
  logic [W-1:0] cnt;
  wire logic differ = cond != state;
  wire logic [W-1:0] limit = state ? W'(CLR_CYCLES - 1) : W'(SET_CYCLES - 1);
  wire logic expire = differ && (cnt == limit);

  // state flips once cond has disagreed with it on limit+1 consecutive edges
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= 1'b0;
      cnt <= '0;
    end else begin
      state <= expire ? ~state : state;
      cnt <= (!differ || expire) ? '0 : cnt + 1'b1;
    end
  end
endmodule : persist_filter
`default_nettype wire

// file: hdl/signal_loss_detector.sv
`timescale 1ns/1ps
`default_nettype none
module signal_loss_detector
  import aeig_pkg::*;
#(
  parameter int unsigned RUN_BITS = LOS_BITS,
  parameter int unsigned ONES_MIN = LOS_ONES_MIN
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic bit_strobe,
  input wire logic bit_one,
  input wire logic loss_cond,
  output logic state
);
  // counters also cover the ones minimum, so a short window cannot truncate the density threshold
  localparam int unsigned WMAX = (RUN_BITS > ONES_MIN) ? RUN_BITS : ONES_MIN;
  localparam int unsigned W = $clog2(WMAX + 1);
  logic [W-1:0] run;
  logic [W-1:0] win;
  logic [W-1:0] ones;
  wire logic run_full = run == W'(RUN_BITS - 1);
  wire logic declare = !state && bit_strobe && loss_cond && run_full;
  wire logic win_end = state && bit_strobe && (win == W'(RUN_BITS - 1));
  wire logic [W-1:0] next_ones = ones + W'(bit_one);
  wire logic dense = win_end && (next_ones >= W'(ONES_MIN));

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= 1'b0;
      run <= '0;
      win <= '0;
      ones <= '0;
    end else begin
      state <= declare | (state & loss_cond & ~dense);
      run <= (!loss_cond || dense) ? '0 : ((bit_strobe && !run_full) ? run + 1'b1 : run);
      win <= (!state || win_end) ? '0 : (bit_strobe ? win + 1'b1 : win);
      ones <= (!state || win_end) ? '0 : (bit_strobe ? next_ones : ones);
    end
  end
endmodule : signal_loss_detector
`default_nettype wire

// file: hdl/alarm_error_interrupt_gating.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_error_interrupt_gating
  import aeig_pkg::*;
#(
  parameter int unsigned AIS_SET_CYCLES = AIS_CYCLES,
  parameter int unsigned RAI_SET_CYCLES = RAI_CYCLES,
  parameter int unsigned LOS_RUN_BITS = LOS_BITS
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire reg_req_t REG_REQ,
  output logic [7:0] RDATA,
  input wire rx_defect_t RX,
  input wire logic SLIP_SRC_IRQ,
  input wire logic FRAMER_SRC_IRQ,
  output logic IRQ
);
  logic [2:0] block_irq_enable;
  logic [3:0] alarm_src_irq_enable;
  logic [3:0] sticky;
  logic [3:0] frame_err_window;
  logic [3:0] frame_err_count_limit;
  logic [3:0] frame_bit_cnt;
  logic [4:0] frame_err_cnt;
  sync_state_t sync_state;
  sync_state_t next_sync_state;
  logic rx_all_ones_state;
  logic rx_remote_alarm_state;
  logic rx_signal_loss_state;
  logic prev_frame_loss;
  logic prev_all_ones;
  logic prev_remote_alarm;

  // register decode
  wire logic sel_block = addr_hit(REG_REQ.addr, BLOCK_IRQ_ENABLE_OFS);
  wire logic sel_status = addr_hit(REG_REQ.addr, ALARM_ERROR_IRQ_STATUS_OFS);
  wire logic sel_src = addr_hit(REG_REQ.addr, ALARM_SRC_IRQ_ENABLE_OFS);
  wire logic sel_thresh = addr_hit(REG_REQ.addr, FRAME_ERR_THRESHOLD_OFS);
  wire logic wr_block = REG_REQ.wr && sel_block;
  wire logic wr_status = REG_REQ.wr && sel_status;
  wire logic wr_src = REG_REQ.wr && sel_src;
  wire logic wr_thresh = REG_REQ.wr && sel_thresh;
  wire logic rd_status = REG_REQ.rd && sel_status;

  wire logic slip_group_irq_en = block_irq_enable[SLIP_GROUP_BIT];
  wire logic alarm_group_irq_en = block_irq_enable[ALARM_GROUP_BIT];
  wire logic framer_group_irq_en = block_irq_enable[FRAMER_GROUP_BIT];

  // out-of-frame declaration over a window of framing bits
  wire logic rx_frame_loss_state = sync_state == OUT_OF_FRAME;
  wire logic [4:0] next_frame_err = frame_err_cnt + 5'(RX.frame_bit_err);
  wire logic window_end = RX.frame_bit_strobe && (frame_bit_cnt == frame_err_window - 4'h1);
  wire logic oof_declare = RX.frame_bit_strobe && (frame_err_count_limit != 4'h0)
                           && (next_frame_err >= {1'b0, frame_err_count_limit});

  always_comb begin
    next_sync_state = sync_state;
    unique case (sync_state)
      IN_FRAME: begin
        if (oof_declare) next_sync_state = OUT_OF_FRAME;
      end
      OUT_OF_FRAME: begin
        if (RX.frame_sync_found) next_sync_state = IN_FRAME;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      sync_state <= IN_FRAME;
      frame_bit_cnt <= 4'h0;
      frame_err_cnt <= 5'h00;
    end else begin
      sync_state <= next_sync_state;
      if (rx_frame_loss_state || oof_declare || window_end) begin
        frame_bit_cnt <= 4'h0;
        frame_err_cnt <= 5'h00;
      end else if (RX.frame_bit_strobe) begin
        frame_bit_cnt <= frame_bit_cnt + 4'h1;
        frame_err_cnt <= next_frame_err;
      end
    end
  end

  // persistence filters for the all-ones and remote alarm defects
  persist_filter #(
    .SET_CYCLES(AIS_SET_CYCLES),
    .CLR_CYCLES(AIS_SET_CYCLES)
  ) u_all_ones (
    .clk(CLK_SYS),
    .srst(SRST),
    .cond(RX.ais_raw),
    .state(rx_all_ones_state)
  );

  persist_filter #(
    .SET_CYCLES(RAI_SET_CYCLES),
    .CLR_CYCLES(RAI_CLEAR_CYCLES)
  ) u_remote_alarm (
    .clk(CLK_SYS),
    .srst(SRST),
    .cond(RX.rai_raw),
    .state(rx_remote_alarm_state)
  );

  signal_loss_detector #(
    .RUN_BITS(LOS_RUN_BITS),
    .ONES_MIN(LOS_ONES_MIN)
  ) u_signal_loss (
    .clk(CLK_SYS),
    .srst(SRST),
    .bit_strobe(RX.bit_strobe),
    .bit_one(RX.bit_one),
    .loss_cond(RX.los_raw),
    .state(rx_signal_loss_state)
  );

  // sticky events: line code violation and the three changes of state
  wire logic [3:0] event_set = {RX.lcv_event,
                                rx_frame_loss_state ^ prev_frame_loss,
                                rx_all_ones_state ^ prev_all_ones,
                                rx_remote_alarm_state ^ prev_remote_alarm};
  wire logic [3:0] event_clr = (rd_status ? 4'hF : 4'h0) | (wr_status ? REG_REQ.wdata[3:0] : 4'h0);
  wire logic [3:0] next_sticky = (sticky & ~event_clr) | event_set;
  wire logic line_code_err_flag = sticky[LINE_CODE_BIT];
  wire logic [7:0] status_view = {rx_frame_loss_state, rx_all_ones_state, rx_remote_alarm_state,
                                  rx_signal_loss_state, sticky};

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      sticky <= STICKY_RST;
      prev_frame_loss <= 1'b0;
      prev_all_ones <= 1'b0;
      prev_remote_alarm <= 1'b0;
    end else begin
      sticky <= next_sticky;
      prev_frame_loss <= rx_frame_loss_state;
      prev_all_ones <= rx_all_ones_state;
      prev_remote_alarm <= rx_remote_alarm_state;
    end
  end

  // writable registers; status bits 7..4 have no storage, so writes to them do nothing
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      block_irq_enable <= BLOCK_IRQ_ENABLE_RST;
      alarm_src_irq_enable <= ALARM_SRC_IRQ_ENABLE_RST;
      frame_err_window <= FRAME_ERR_WINDOW_RST;
      frame_err_count_limit <= FRAME_ERR_LIMIT_RST;
    end else begin
      if (wr_block) block_irq_enable <= REG_REQ.wdata[2:0];
      if (wr_src) alarm_src_irq_enable <= REG_REQ.wdata[3:0];
      if (wr_thresh) begin
        frame_err_window <= REG_REQ.wdata[WINDOW_LSB +: 4];
        frame_err_count_limit <= REG_REQ.wdata[LIMIT_LSB +: 4];
      end
    end
  end

  // read data, valid only in the cycle after the read strobe
  wire logic [7:0] read_mux = sel_block ? {5'h00, block_irq_enable} :
                              sel_status ? status_view :
                              sel_src ? {4'h0, alarm_src_irq_enable} :
                              sel_thresh ? {frame_err_window, frame_err_count_limit} : 8'h00;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= REG_REQ.rd ? read_mux : 8'h00;
    end
  end

  // interrupt: each group needs its block enable and a source-level request
  wire logic alarm_pending = |(sticky & alarm_src_irq_enable);
  wire logic slip_path = slip_group_irq_en && SLIP_SRC_IRQ;
  wire logic alarm_path = alarm_group_irq_en && alarm_pending;
  wire logic framer_path = framer_group_irq_en && FRAMER_SRC_IRQ;
  assign IRQ = slip_path || alarm_path || framer_path;

  // helper counters used only by the checks below
  logic [31:0] ais_on_run;
  logic [31:0] ais_off_run;
  logic [31:0] rai_on_run;
  logic [31:0] los_bit_run;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ais_on_run <= 32'h0000_0000;
      ais_off_run <= 32'h0000_0000;
      rai_on_run <= 32'h0000_0000;
      los_bit_run <= 32'h0000_0000;
    end else begin
      ais_on_run <= RX.ais_raw ? ais_on_run + 32'h0000_0001 : 32'h0000_0000;
      ais_off_run <= RX.ais_raw ? 32'h0000_0000 : ais_off_run + 32'h0000_0001;
      rai_on_run <= RX.rai_raw ? rai_on_run + 32'h0000_0001 : 32'h0000_0000;
      if (!RX.los_raw) los_bit_run <= 32'h0000_0000;
      else if (RX.bit_strobe) los_bit_run <= los_bit_run + 32'h0000_0001;
    end
  end

  default clocking cb_sys @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  sequence s_status_read_quiet;
    rd_status && !RX.lcv_event;
  endsequence

  sequence s_remote_alarm_gone;
    rx_remote_alarm_state && !RX.rai_raw;
  endsequence

  sequence s_loss_gone;
    rx_signal_loss_state && !RX.los_raw;
  endsequence

  sequence s_frame_loss_change;
    rx_frame_loss_state != prev_frame_loss;
  endsequence

  sequence s_sync_regained;
    rx_frame_loss_state && RX.frame_sync_found;
  endsequence

  sequence s_read_with_event;
    rd_status && RX.lcv_event;
  endsequence

  sequence s_lcv_write_clear;
    wr_status && REG_REQ.wdata[LINE_CODE_BIT] && !RX.lcv_event;
  endsequence

  sequence s_loss_held;
    rx_signal_loss_state && RX.los_raw && !RX.bit_strobe;
  endsequence

  AST_SLIP_BLOCKED: assert property (!slip_group_irq_en && !alarm_path && !framer_path |-> !IRQ)
    else $error("slip source reached the pin with its block disabled");

  AST_ALARM_BLOCKED: assert property (!alarm_group_irq_en && !slip_path && !framer_path |-> !IRQ)
    else $error("alarm source reached the pin with its block disabled");

  AST_FRAMER_BLOCKED: assert property (!framer_group_irq_en && !slip_path && !alarm_path |-> !IRQ)
    else $error("framer source reached the pin with its block disabled");

  AST_IRQ_NEEDS_BOTH: assert property (IRQ |-> (slip_group_irq_en && SLIP_SRC_IRQ)
      || (alarm_group_irq_en && |(sticky & alarm_src_irq_enable))
      || (framer_group_irq_en && FRAMER_SRC_IRQ))
    else $error("interrupt pin high without block and source enables");

  AST_ENABLE_ALONE_QUIET: assert property (!alarm_pending && !SLIP_SRC_IRQ && !FRAMER_SRC_IRQ |-> !IRQ)
    else $error("block enable alone asserted the interrupt pin");

  AST_OOF_READBACK: assert property (rd_status |=> RDATA[FRAME_LOSS_BIT] == $past(rx_frame_loss_state))
    else $error("status bit 7 does not reflect the out-of-frame state");

  AST_OOF_CAUSE: assert property ($rose(rx_frame_loss_state) |-> $past(RX.frame_bit_strobe && RX.frame_bit_err))
    else $error("out-of-frame declared without a framing bit error");

  AST_AIS_DECLARE: assert property ($rose(rx_all_ones_state) |-> ais_on_run >= AIS_SET_CYCLES)
    else $error("all-ones defect declared before its persistence time");

  AST_AIS_READBACK: assert property (rd_status |=> RDATA[ALL_ONES_BIT] == $past(rx_all_ones_state))
    else $error("status bit 6 does not reflect the all-ones state");

  AST_AIS_CLEAR: assert property ($fell(rx_all_ones_state) |-> ais_off_run >= AIS_SET_CYCLES)
    else $error("all-ones defect cleared before its absence time");

  AST_YEL_DECLARE: assert property ($rose(rx_remote_alarm_state) |-> rai_on_run >= RAI_SET_CYCLES)
    else $error("remote alarm declared before its persistence time");

  AST_YEL_CLEAR_AT_ONCE: assert property (s_remote_alarm_gone |=> !rx_remote_alarm_state)
    else $error("remote alarm not cleared at once");

  AST_LOS_DECLARE: assert property ($rose(rx_signal_loss_state) |-> los_bit_run >= LOS_RUN_BITS)
    else $error("signal loss declared before enough lost bits");

  AST_LOS_CLEAR: assert property (s_loss_gone |=> !rx_signal_loss_state)
    else $error("signal loss not cleared when the condition went away");

  AST_LCV_LATCH: assert property (RX.lcv_event |=> line_code_err_flag
      ##1 (line_code_err_flag || $past(event_clr[LINE_CODE_BIT])))
    else $error("line code violation not latched");

  AST_LCV_READ_CLEAR: assert property (s_status_read_quiet ##0 line_code_err_flag
      |=> !line_code_err_flag && RDATA[LINE_CODE_BIT])
    else $error("line code flag not returned and cleared by read");

  AST_COS_OOF: assert property (s_frame_loss_change |=> sticky[FRAME_LOSS_CHG_BIT])
    else $error("out-of-frame change not flagged");

  AST_COS_AIS: assert property ($changed(rx_all_ones_state) |=> sticky[ALL_ONES_CHG_BIT])
    else $error("all-ones change not flagged");

  AST_COS_YEL: assert property ($changed(rx_remote_alarm_state) |=> sticky[REMOTE_ALARM_CHG_BIT])
    else $error("remote alarm change not flagged");

  AST_RESET_CLEARS: assert property (@(posedge CLK_SYS) disable iff (1'b0) SRST |=> status_view == 8'h00
      && block_irq_enable == BLOCK_IRQ_ENABLE_RST)
    else $error("status or block enables not zero after reset");

  AST_RO_WRITE_IGNORED: assert property (wr_status && !(|event_set) && (REG_REQ.wdata[3:0] == 4'h0)
      |=> $stable(sticky))
    else $error("write to read-only status bits changed stored state");

  AST_OOF_CLEAR: assert property (s_sync_regained |=> !rx_frame_loss_state)
    else $error("out-of-frame not cleared when alignment was regained");

  AST_AIS_HOLD: assert property (rx_all_ones_state && RX.ais_raw |=> rx_all_ones_state)
    else $error("all-ones defect dropped while the condition was present");

  AST_YEL_HOLD: assert property (rx_remote_alarm_state && RX.rai_raw |=> rx_remote_alarm_state)
    else $error("remote alarm dropped while the condition was present");

  AST_LOS_HOLD: assert property (s_loss_held |=> rx_signal_loss_state)
    else $error("signal loss dropped while the loss condition was present");

  AST_LCV_SET_WINS: assert property (s_read_with_event |=> line_code_err_flag)
    else $error("line code violation lost when it met a status read");

  AST_LCV_WRITE_CLEAR: assert property (s_lcv_write_clear |=> !line_code_err_flag)
    else $error("line code flag not cleared by writing one");

  AST_ALARM_IRQ_FOLLOWS: assert property (alarm_group_irq_en && alarm_pending |-> IRQ)
    else $error("enabled alarm request did not reach the pin");

  AST_SLIP_IRQ_FOLLOWS: assert property (slip_group_irq_en && SLIP_SRC_IRQ |-> IRQ)
    else $error("enabled slip request did not reach the pin");

  AST_FRAMER_IRQ_FOLLOWS: assert property (framer_group_irq_en && FRAMER_SRC_IRQ |-> IRQ)
    else $error("enabled framer request did not reach the pin");

endmodule : alarm_error_interrupt_gating
`default_nettype wire

// file: bench/rx_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module rx_line_model
  import aeig_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic los,
  input wire logic ais,
  input wire logic rai,
  input wire logic lcv_req,
  input wire logic fbit_req,
  input wire logic fbit_err,
  input wire logic sync_req,
  output wire rx_defect_t rx
);
  logic [1:0] div;
  logic [7:0] lfsr;
  wire logic bit_tick = (div == 2'h3);

  // one received bit every four clocks; data scrambles so idle lines never look stable
  always_ff @(posedge clk) begin
    if (srst) begin
      div <= 2'h0;
      lfsr <= 8'h5A;
    end else begin
      div <= div + 2'h1;
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  assign rx.bit_strobe = bit_tick;
  // a lost signal carries no ones
  assign rx.bit_one = los ? 1'b0 : lfsr[0];
  assign rx.los_raw = los;
  assign rx.ais_raw = ais;
  assign rx.rai_raw = rai;
  assign rx.frame_bit_strobe = fbit_req;
  // error flag is only meaningful with its strobe; otherwise it wanders
  assign rx.frame_bit_err = fbit_req ? fbit_err : lfsr[1];
  assign rx.frame_sync_found = sync_req;
  assign rx.lcv_event = lcv_req;
endmodule : rx_line_model
`default_nettype wire

// file: bench/alarm_error_interrupt_gating_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module alarm_error_interrupt_gating_test
  import aeig_pkg::*;
;
  logic clk_sys;
  logic srst;
  reg_req_t req;
  logic [7:0] rdata;
  rx_defect_t rx;
  logic slip_src;
  logic framer_src;
  logic irq;
  logic los, ais, rai, lcv_req, fbit_req, fbit_err, sync_req;
  int err_total;
  int checked;
  logic [2:0] blk;
  logic lcv_sticky;

  alarm_error_interrupt_gating #(
    .AIS_SET_CYCLES(20),
    .RAI_SET_CYCLES(40),
    .LOS_RUN_BITS(8)
  ) i_alarm_error_interrupt_gating (
    .CLK_SYS(clk_sys),
    .SRST(srst),
    .REG_REQ(req),
    .RDATA(rdata),
    .RX(rx),
    .SLIP_SRC_IRQ(slip_src),
    .FRAMER_SRC_IRQ(framer_src),
    .IRQ(irq)
  );

  rx_line_model i_rx_line_model (
    .clk(clk_sys),
    .srst(srst),
    .los(los),
    .ais(ais),
    .rai(rai),
    .lcv_req(lcv_req),
    .fbit_req(fbit_req),
    .fbit_err(fbit_err),
    .sync_req(sync_req),
    .rx(rx)
  );

  function automatic logic irq_exp(input logic [2:0] b, input logic s, input logic a, input logic f);
    return (b[SLIP_GROUP_BIT] & s) | (b[ALARM_GROUP_BIT] & a) | (b[FRAMER_GROUP_BIT] & f);
  endfunction : irq_exp

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req <= '0;
  endtask : wr_reg

  task automatic check_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1;
    `CHK(rdata, exp)
  endtask : check_reg

  task automatic pulse_lcv();
    @(posedge clk_sys);
    lcv_req <= 1'b1;
    @(posedge clk_sys);
    lcv_req <= 1'b0;
  endtask : pulse_lcv

  task automatic frame_bit(input logic err, input logic sync);
    @(posedge clk_sys);
    fbit_req <= ~sync;
    fbit_err <= err;
    sync_req <= sync;
    @(posedge clk_sys);
    fbit_req <= 1'b0;
    sync_req <= 1'b0;
  endtask : frame_bit

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin : watchdog
    for (int n = 0; n < 20000; n++) @(posedge clk_sys);
    err_total++;
    close_out();
  end

  initial begin
    srst = 1'b1;
    req = '0;
    slip_src = 1'b0;
    framer_src = 1'b0;
    {los, ais, rai, lcv_req, fbit_req, fbit_err, sync_req} = 7'h00;
    err_total = 0;
    checked = 0;
    void'($urandom(50154));
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    `CHK(irq, 1'b0)
    check_reg(BLOCK_IRQ_ENABLE_OFS, 8'h00);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h00);
    check_reg(ALARM_SRC_IRQ_ENABLE_OFS, 8'h00);
    check_reg(FRAME_ERR_THRESHOLD_OFS, {FRAME_ERR_WINDOW_RST, FRAME_ERR_LIMIT_RST});
    end_test("reset");

    repeat (1 + $urandom % 3) pulse_lcv();
    wr_reg(BLOCK_IRQ_ENABLE_OFS, 8'h07);
    #1;
    `CHK(irq, 1'b0)
    wr_reg(ALARM_SRC_IRQ_ENABLE_OFS, 8'h08);
    lcv_sticky = 1'b1;
    for (int i = 0; i < 16; i++) begin
      blk = i[2:0];
      wr_reg(BLOCK_IRQ_ENABLE_OFS, {5'h00, blk});
      slip_src <= 1'($urandom);
      framer_src <= 1'($urandom);
      @(posedge clk_sys);
      #1;
      `CHK(irq, irq_exp(blk, slip_src, lcv_sticky, framer_src))
    end
    wr_reg(16'h0B01, 8'hFF);
    check_reg(16'h0B01, 8'h00);
    check_reg(BLOCK_IRQ_ENABLE_OFS, {5'h00, blk});
    check_reg(ALARM_SRC_IRQ_ENABLE_OFS, 8'h08);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h08);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h00);
    // violation in the very cycle of a status read: the set must win
    fork
      pulse_lcv();
      check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h00);
    join
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h08);
    pulse_lcv();
    wr_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h08);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h00);
    slip_src <= 1'b0;
    framer_src <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK(irq, 1'b0)
    end_test("gating");

    @(posedge clk_sys);
    ais <= 1'b1;
    repeat (15) @(posedge clk_sys);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h00);
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK(irq, 1'b0)
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h42);
    wr_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h00);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h40);
    ais <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h40);
    repeat (12) @(posedge clk_sys);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h02);
    end_test("all ones");

    wr_reg(ALARM_SRC_IRQ_ENABLE_OFS, 8'h01);
    @(posedge clk_sys);
    rai <= 1'b1;
    repeat (30) @(posedge clk_sys);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h00);
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK(irq, 1'b1)
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h21);
    `CHK(irq, 1'b0)
    rai <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h01);
    end_test("remote alarm");

    @(posedge clk_sys);
    los <= 1'b1;
    repeat (20) @(posedge clk_sys);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h00);
    repeat (16) @(posedge clk_sys);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h10);
    los <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h00);
    end_test("signal loss");

    frame_bit(1'b1, 1'b0);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h00);
    frame_bit(1'b1, 1'b0);
    repeat (2) @(posedge clk_sys);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h84);
    frame_bit(1'b0, 1'b1);
    repeat (2) @(posedge clk_sys);
    check_reg(ALARM_ERROR_IRQ_STATUS_OFS, 8'h04);
    end_test("frame loss");
    close_out();
  end
endmodule : alarm_error_interrupt_gating_test
`default_nettype wire
